// ===== core/dhb_bridge.sv
// dhb_bridge: local address decode, host command port and dma hold sequencer
// assumes: host signals and the host phase-2 clock arrive asynchronously
// Operation
// R1 - decoder enabled only when address bits 15..13 low; bits 12..10 pick select
// R2 - interrupt acknowledge low forces all region selects inactive
// R3 - 0000-03FF first rom, 0400-07FF second rom, bits 9..0 pick word
// R4 - 08XX through 09XX selects the 512-byte ram in two banks
// R5 - in ram, bit 8 picks bank and bits 7..0 pick byte
// R6 - ram output enable follows read strobe, write control follows write strobe
// R7 - on-board memory accesses never insert wait states
// R8 - host command port address is an 8-bit constant from 0 to 255
// R9 - latch strobe needs port match, host write and output cycle; captures data
// R10 - captured byte sets pending flag, drives pending low, starts hold request
// R11 - local read at 1800H returns pending flag on data bit 0
// R12 - local read at 1400H drives latched command byte onto data bus
// R13 - reading command byte clears pending flag and withdraws hold request
// R14 - local access in upper 32K becomes dma in lower 32K of host space
// R15 - external latch may redirect dma into upper 32K of host space
// R16 - bit 15 high with a strobe stalls processor and raises hold request
// R17 - sequencer leaves clear only while pending-n and priority-in high; code gates on priority-in and hold line, and cmd_pending_n low starts it
// R18 - if hold line free, first stage sets on phase-2 fall, pulls hold
// R19 - host raises hold acknowledge; device then drives host buses
// R20 - second stage asserts dma active and enables buffers, direction by read
// R21 - host write to command port triggers a similar hold sequence
// R22 - priority-out low when priority-in low or own dma active; code also pulls it low in the hold request and parked states
// R23 - priority-in falling before next phase-2 fall aborts the dma
// R24 - dma ends when both strobes high; bus returned only if nothing pending
// R25 - local writes to command addresses leave latch and flag unchanged
`default_nettype none
module dhb_bridge #(
  parameter logic [7:0] CMD_PORT_ADDR = dhb_pkg::CMD_PORT_DEFAULT
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // local processor bus
  input wire dhb_pkg::dhb_local_bus_t local_bus,
  input wire logic [7:0] local_wdata,
  output logic [7:0] local_rdata,
  output logic local_rdata_valid,
  output logic local_ready_in,
  output logic [7:0] region_select_n,
  // external host page latch
  input wire logic host_upper_page,
  // host command cycle, asynchronous
  input wire dhb_pkg::dhb_host_cmd_t host_cmd,
  // host hold handshake
  input wire logic host_phi2,
  input wire logic host_hold_ack,
  input wire logic host_hold_in,
  input wire logic prio_in_n,
  input wire logic host_ready,
  output logic host_hold_req_n,
  output logic host_hold_oe_n,
  output logic prio_out_n,
  // host bus drive during dma
  output logic host_bus_oe_n,
  output logic [15:0] host_addr,
  output logic host_mem_rd,
  output logic host_mem_wr,
  output logic [7:0] host_wdata,
  input wire logic [7:0] host_rdata,
  output logic data_buf_en,
  output logic data_buf_to_local,
  // status
  output logic dma_active,
  output logic cmd_pending_n,
  output logic cmd_latch_strobe
);
  import dhb_pkg::*;

  // ------------------------------------------------------------
  // synchronisers
  // ------------------------------------------------------------
  localparam int unsigned SYNC_W = 24;
  logic [SYNC_W-1:0] sync_a;
  logic [SYNC_W-1:0] sync_b;
  logic [SYNC_W-1:0] raw_in;
  assign raw_in = {host_cmd, host_phi2, host_hold_ack, host_hold_in, prio_in_n, host_ready,
    host_upper_page};

  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
      always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
          sync_a[gi] <= 1'b0;
          sync_b[gi] <= 1'b0;
        end else begin
          sync_a[gi] <= raw_in[gi];
          sync_b[gi] <= sync_a[gi];
        end
      end
    end
  endgenerate

  dhb_host_cmd_t s_cmd;
  logic s_phi2, s_ack, s_hold_in, s_prio_n, s_ready, s_upper;
  assign s_cmd = sync_b[23:6];
  assign s_phi2 = sync_b[5];
  assign s_ack = sync_b[4];
  assign s_hold_in = sync_b[3];
  assign s_prio_n = sync_b[2];
  assign s_ready = sync_b[1];
  assign s_upper = sync_b[0];

  logic phi2_d;
  logic phi2_fall;
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      phi2_d <= 1'b0;
    end else begin
      phi2_d <= s_phi2;
    end
  end
  assign phi2_fall = phi2_d && !s_phi2;

  // ------------------------------------------------------------
  // local address decode
  // ------------------------------------------------------------
  logic dec_en;
  logic [2:0] region;
  logic any_strobe;
  logic dma_window;
  assign dec_en = (local_bus.addr[ADDR_MSB -: 3] == DEC_ENABLE_TOP) && local_bus.int_ack_n; // see R1 see R2
  assign region = local_bus.addr[REGION_HI:REGION_LO];
  assign any_strobe = !local_bus.mem_rd_n || !local_bus.mem_wr_n;
  assign dma_window = local_bus.addr[ADDR_MSB] && any_strobe; // see R16

  generate
    for (gi = 0; gi < REGION_W; gi++) begin : g_region
      assign region_select_n[gi] = !(dec_en && (region == 3'(gi))); // see R1 see R3 see R4
    end
  endgenerate

  logic sel_ram, sel_data, sel_status;
  logic ram_rd, ram_wr;
  assign sel_ram = !region_select_n[REG_RAM];
  assign sel_data = !region_select_n[REG_CMD_DATA];
  assign sel_status = !region_select_n[REG_CMD_STATUS];
  assign ram_rd = sel_ram && !local_bus.mem_rd_n; // see R6
  assign ram_wr = sel_ram && !local_bus.mem_wr_n; // see R6

  logic [7:0] ram_rdata;
  dhb_local_ram u_ram (
    .mclk(mclk),
    .select(sel_ram),
    .bank(local_bus.addr[RAM_BANK_BIT]), // see R5
    .byte_addr(local_bus.addr[RAM_BYTE_HI:0]), // see R5
    .rd(ram_rd),
    .wr(ram_wr),
    .wdata(local_wdata),
    .rdata(ram_rdata)
  );

  // ------------------------------------------------------------
  // host command port
  // ------------------------------------------------------------
  logic port_addr_match;
  logic strobe_d;
  logic strobe_rise;
  logic [7:0] cmd_byte;
  logic pending;
  logic rd_d;
  logic data_read;
  assign port_addr_match = (s_cmd.port_addr == CMD_PORT_ADDR); // see R8
  assign cmd_latch_strobe = port_addr_match && s_cmd.host_write_strobe && s_cmd.host_output_cycle; // see R9
  assign strobe_rise = cmd_latch_strobe && !strobe_d;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      strobe_d <= 1'b0;
      rd_d <= 1'b1;
    end else begin
      strobe_d <= cmd_latch_strobe;
      rd_d <= local_bus.mem_rd_n;
    end
  end
  // one clear per read cycle, on its leading edge; writes never clear
  assign data_read = sel_data && !local_bus.mem_rd_n && rd_d; // see R13 see R25

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      cmd_byte <= BYTE_ZERO;
    end else if (strobe_rise) begin
      cmd_byte <= s_cmd.data; // see R9
    end
  end

  // a new byte landing in the read cycle keeps the flag set
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      pending <= 1'b0;
    end else if (strobe_rise) begin
      pending <= 1'b1; // see R10 see R21
    end else if (data_read) begin
      pending <= 1'b0; // see R13
    end
  end
  assign cmd_pending_n = !pending; // see R10

  // ------------------------------------------------------------
  // local read data
  // ------------------------------------------------------------
  dhb_seq_t dma_state;
  logic rd_ram_q;
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      local_rdata <= BYTE_ZERO;
      local_rdata_valid <= 1'b0;
      rd_ram_q <= 1'b0;
    end else begin
      rd_ram_q <= ram_rd;
      local_rdata_valid <= 1'b0;
      if (sel_status && !local_bus.mem_rd_n) begin
        local_rdata <= STATUS_REST;
        local_rdata[STATUS_PEND_BIT] <= pending; // see R11
        local_rdata_valid <= 1'b1;
      end else if (sel_data && !local_bus.mem_rd_n) begin
        local_rdata <= cmd_byte; // see R12
        local_rdata_valid <= 1'b1;
      end else if (rd_ram_q) begin
        local_rdata <= ram_rdata;
        local_rdata_valid <= 1'b1;
      end else if (dma_state == SEQ_DMA && !local_bus.mem_rd_n && host_mem_rd && s_ready) begin
        local_rdata <= host_rdata;
        local_rdata_valid <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // hold sequencer
  // ------------------------------------------------------------
  logic hold_req;
  logic seq_enable;
  logic dma_done;
  assign hold_req = dma_window || pending; // see R16 see R10 see R21
  assign seq_enable = s_prio_n; // see R17
  assign dma_done = local_bus.mem_rd_n && local_bus.mem_wr_n; // see R24

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      dma_state <= SEQ_CLEAR;
    end else begin
      unique case (dma_state)
        SEQ_CLEAR: begin
          if (hold_req && seq_enable && s_hold_in && phi2_fall) begin
            dma_state <= SEQ_HOLD_REQ; // see R17 see R18
          end
        end
        SEQ_HOLD_REQ: begin
          if (!s_prio_n && !s_ack) begin
            dma_state <= SEQ_CLEAR; // see R23
          end else if (s_ack) begin
            dma_state <= dma_window ? SEQ_DMA : SEQ_PARKED; // see R19
          end else if (!hold_req) begin
            dma_state <= SEQ_CLEAR;
          end
        end
        SEQ_DMA: begin
          if (dma_done) begin
            dma_state <= pending ? SEQ_PARKED : SEQ_CLEAR; // see R24
          end
        end
        SEQ_PARKED: begin
          // host stays held while a command waits; dma runs without new handshake
          if (dma_window) begin
            dma_state <= SEQ_DMA;
          end else if (!pending) begin
            dma_state <= SEQ_CLEAR; // see R24
          end
        end
      endcase
    end
  end

  assign host_hold_req_n = (dma_state == SEQ_CLEAR); // see R18
  assign host_hold_oe_n = host_hold_req_n;
  assign dma_active = (dma_state == SEQ_DMA); // see R20
  assign prio_out_n = !(!s_prio_n || dma_state != SEQ_CLEAR); // see R22
  // ready waits for the host strobe, so read data is on the host bus when the cpu moves on
  assign local_ready_in = !(dma_window && !(dma_active && s_ready && (host_mem_rd || host_mem_wr))); // see R7 see R16

  // ------------------------------------------------------------
  // host bus drive
  // ------------------------------------------------------------
  assign host_bus_oe_n = !(dma_state == SEQ_DMA || dma_state == SEQ_PARKED); // see R19
  assign data_buf_en = dma_active; // see R20
  assign data_buf_to_local = !local_bus.mem_rd_n; // see R20

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      host_addr <= '0;
      host_mem_rd <= 1'b0;
      host_mem_wr <= 1'b0;
      host_wdata <= BYTE_ZERO;
    end else begin
      host_addr <= {s_upper, local_bus.addr[ADDR_MSB-1:0]}; // see R14 see R15
      host_mem_rd <= dma_active && !local_bus.mem_rd_n; // see R14
      host_mem_wr <= dma_active && !local_bus.mem_wr_n; // see R14
      host_wdata <= local_wdata;
    end
  end
endmodule
`default_nettype wire

// ===== include/dhb_pkg.sv
// dhb_pkg: constants and carrier types for the host bridge and command port
// assumes: a single mclk domain; host phase-2 clock is sampled as a pin
`default_nettype none
package dhb_pkg;
  // local address map
  localparam int unsigned ADDR_MSB = 15;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned REGION_W = 8;
  localparam logic [2:0] DEC_ENABLE_TOP = 3'h0;
  localparam logic [15:0] CMD_DATA_ADDR = 16'h1400;
  localparam logic [15:0] CMD_STATUS_ADDR = 16'h1800;
  localparam int unsigned REGION_LO = 10;
  localparam int unsigned REGION_HI = 12;
  localparam logic [2:0] REG_PROM0 = 3'h0;
  localparam logic [2:0] REG_PROM1 = 3'h1;
  localparam logic [2:0] REG_RAM = 3'h2;
  localparam logic [2:0] REG_CMD_DATA = 3'h5;
  localparam logic [2:0] REG_CMD_STATUS = 3'h6;
  localparam int unsigned ROM_WORD_HI = 9;
  localparam int unsigned RAM_BANK_BIT = 8;
  localparam int unsigned RAM_BYTE_HI = 7;
  localparam int unsigned RAM_DEPTH = 512;
  localparam int unsigned RAM_AW = 9;
  localparam int unsigned STATUS_PEND_BIT = 0;
  localparam logic [7:0] STATUS_REST = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  // default host command port address, 0 to 255
  localparam logic [7:0] CMD_PORT_DEFAULT = 8'h00;

  // local processor bus request
  typedef struct packed {
    logic [15:0] addr;
    logic mem_rd_n;
    logic mem_wr_n;
    logic int_ack_n;
  } dhb_local_bus_t;

  // host side output cycle
  typedef struct packed {
    logic [7:0] port_addr;
    logic [7:0] data;
    logic host_write_strobe;
    logic host_output_cycle;
  } dhb_host_cmd_t;

  // hold sequencer states, one-hot
  typedef enum logic [3:0] {
    SEQ_CLEAR = 4'h1,
    SEQ_HOLD_REQ = 4'h2,
    SEQ_DMA = 4'h4,
    SEQ_PARKED = 4'h8
  } dhb_seq_t;
endpackage
`default_nettype wire

// ===== core/dhb_local_ram.sv
// dhb_local_ram: 512-byte on-board ram, two 256-byte banks
// assumes: strobes already synchronous to mclk, single cycle access
`default_nettype none
module dhb_local_ram (
  // clock
  input wire logic mclk,
  // access
  input wire logic select,
  input wire logic bank,
  input wire logic [7:0] byte_addr,
  input wire logic rd,
  input wire logic wr,
  input wire logic [7:0] wdata,
  // read data
  output logic [7:0] rdata
);
  import dhb_pkg::*;
  logic [7:0] mem [0:RAM_DEPTH-1];
  logic [RAM_AW-1:0] index;

  assign index = {bank, byte_addr};
  // storage holds no reset: contents are undefined at power up like the chips
  always_ff @(posedge mclk) begin
    if (select && wr) begin
      mem[index] <= wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (select && rd) begin
      rdata <= mem[index];
    end
  end
endmodule
`default_nettype wire

// ===== testbench/dhb_bridge_monitor.sv
// dhb_bridge_monitor: port checks on the bridge
// assumes: bound to dhb_bridge, single mclk domain
`default_nettype none
module dhb_bridge_monitor (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // observed ports
  input wire dhb_pkg::dhb_local_bus_t local_bus,
  input wire logic local_ready_in,
  input wire logic [7:0] region_select_n,
  input wire logic cmd_pending_n,
  input wire logic cmd_latch_strobe,
  input wire logic dma_active,
  input wire logic prio_out_n,
  input wire logic host_bus_oe_n,
  input wire logic data_buf_en,
  input wire logic data_buf_to_local
);
  timeunit 1ns;
  timeprecision 1ps;
  import dhb_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  // ---------------------------------
  // properties
  // ---------------------------------
  property p_dec_off;
    local_bus.addr[15:13] != 3'h0 |-> region_select_n == 8'hff;
  endproperty
  a_dec_off: assert property (p_dec_off) else $error("decoder active above 1fff");
  property p_int_ack_n;
    !local_bus.int_ack_n |-> region_select_n == 8'hff;
  endproperty
  a_int_ack_n: assert property (p_int_ack_n) else $error("select during int ack");
  property p_rom;
    local_bus.int_ack_n && local_bus.addr[15:11] == 5'h00 |-> region_select_n == (local_bus.addr[10] ? 8'hfd : 8'hfe);
  endproperty
  a_rom: assert property (p_rom) else $error("rom select wrong");
  property p_ram;
    local_bus.int_ack_n && local_bus.addr[15:9] == 7'h04 |-> region_select_n == 8'hfb;
  endproperty
  a_ram: assert property (p_ram) else $error("ram select wrong");
  property p_nowait;
    !local_bus.addr[15] |-> local_ready_in;
  endproperty
  a_nowait: assert property (p_nowait) else $error("wait on local access");
  property p_stall;
    local_bus.addr[15] && !(local_bus.mem_rd_n && local_bus.mem_wr_n) && !dma_active |-> !local_ready_in;
  endproperty
  a_stall: assert property (p_stall) else $error("no stall on dma access");
  property p_pend;
    $rose(cmd_latch_strobe) |=> !cmd_pending_n;
  endproperty
  a_pend: assert property (p_pend) else $error("pending not set");
  property p_clear;
    local_bus.addr == 16'h1400 && !local_bus.mem_rd_n && !cmd_latch_strobe |-> ##[1:3] cmd_pending_n;
  endproperty
  a_clear: assert property (p_clear) else $error("pending not cleared");
  property p_prio;
    dma_active |-> !prio_out_n;
  endproperty
  a_prio: assert property (p_prio) else $error("priority out high in dma");
  property p_dma_bus;
    dma_active |-> !host_bus_oe_n && data_buf_en && data_buf_to_local == !local_bus.mem_rd_n;
  endproperty
  a_dma_bus: assert property (p_dma_bus) else $error("host bus not driven in dma");
  c_dma: cover property ($rose(dma_active));
  c_cmd: cover property ($fell(cmd_pending_n));
  c_int_ack_n: cover property (!local_bus.int_ack_n);
endmodule
`default_nettype wire

// ===== testbench/dhb_host_model.sv
// dhb_host_model: host processor side of the hold handshake and memory
// assumes: bridge drives host bus only while acknowledged
`default_nettype none
module dhb_host_model (
  // handshake
  input wire logic mclk,
  input wire logic slow,
  input wire logic host_hold_req_n,
  output logic host_phi2,
  output logic host_hold_ack,
  output logic host_hold_in,
  output logic host_ready,
  // memory
  input wire logic [15:0] host_addr,
  input wire logic host_mem_rd,
  input wire logic host_mem_wr,
  input wire logic [7:0] host_wdata,
  output logic [7:0] host_rdata,
  output logic [15:0] wr_addr,
  output logic [7:0] wr_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic ack_d;
  initial begin
    host_phi2 = 1'b0;
    host_hold_ack = 1'b0;
    ack_d = 1'b0;
    wr_addr = 16'h0000;
    wr_data = 8'h00;
  end
  // phase-2 runs free, as the host clock never stops
  always #40 host_phi2 = ~host_phi2;
  assign host_hold_in = 1'b1;
  always @(negedge host_phi2) begin
    host_hold_ack <= !host_hold_req_n;
    ack_d <= host_hold_ack;
  end
  assign host_ready = slow ? ack_d : host_hold_ack;
  // released bus toggles so a stale byte is never taken
  assign host_rdata = host_mem_rd ? ~host_addr[7:0] : {4{host_phi2, ~host_phi2}};
  always @(posedge mclk) begin
    if (host_mem_wr) begin
      wr_addr <= host_addr;
      wr_data <= host_wdata;
    end
  end
endmodule
`default_nettype wire

// ===== testbench/tb_top.sv
// tb_top: bridge bench with host model
// assumes: design and monitor compiled first
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import dhb_pkg::*;
  logic mclk, reset, local_rdata_valid, local_ready_in, host_upper_page, host_phi2, host_hold_ack;
  logic host_hold_in, prio_in_n, host_ready, host_hold_req_n, host_hold_oe_n, prio_out_n, host_bus_oe_n;
  logic host_mem_rd, host_mem_wr, data_buf_en, data_buf_to_local, dma_active, cmd_pending_n;
  logic cmd_latch_strobe, slow;
  logic [7:0] local_wdata, local_rdata, region_select_n, host_wdata, host_rdata, wr_data, q;
  logic [15:0] host_addr, wr_addr;
  dhb_local_bus_t local_bus;
  dhb_host_cmd_t host_cmd;
  int n_errors = 0;
  int n_checks = 0;
  int cycles = 0;
  dhb_bridge #(.CMD_PORT_ADDR(8'h3c)) uut (.mclk, .reset, .local_bus, .local_wdata, .local_rdata,
    .local_rdata_valid, .local_ready_in, .region_select_n, .host_upper_page, .host_cmd, .host_phi2,
    .host_hold_ack, .host_hold_in, .prio_in_n, .host_ready, .host_hold_req_n, .host_hold_oe_n,
    .prio_out_n, .host_bus_oe_n, .host_addr, .host_mem_rd, .host_mem_wr, .host_wdata, .host_rdata,
    .data_buf_en, .data_buf_to_local, .dma_active, .cmd_pending_n, .cmd_latch_strobe);
  dhb_host_model host (.mclk, .slow, .host_hold_req_n, .host_phi2, .host_hold_ack, .host_hold_in,
    .host_ready, .host_addr, .host_mem_rd, .host_mem_wr, .host_wdata, .host_rdata, .wr_addr, .wr_data);
  // ---------------------------------
  // tasks
  // ---------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    $display("checks=%0d errors=%0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // one local cycle; strobe held until ready is seen high
  task automatic bus(input logic [15:0] a, input logic rd, input logic [7:0] d, output logic [7:0] r);
    int k;
    @(posedge mclk);
    #1;
    local_bus = '{a, !rd, rd, 1'b1};
    local_wdata = d;
    k = 0;
    do @(negedge mclk); while (local_ready_in !== 1'b1 && ++k < 500);
    chk(local_ready_in, 1'b1);
    @(posedge mclk);
    #1;
    local_bus = '{16'h2000, 1'b1, 1'b1, 1'b1};
    k = 0;
    while (rd && local_rdata_valid !== 1'b1 && k < 20) begin
      @(negedge mclk);
      k++;
    end
    if (rd) chk(local_rdata_valid, 1'b1);
    r = local_rdata;
  endtask
  task automatic host_out(input logic [7:0] p, input logic [7:0] d);
    @(posedge mclk);
    #1;
    host_cmd = '{p, d, 1'b1, 1'b1};
    repeat (4) @(posedge mclk);
    #1;
    host_cmd = '{p, d, 1'b0, 1'b0};
    repeat (6) @(posedge mclk);
  endtask
  // ---------------------------------
  // sequence
  // ---------------------------------
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      give_verdict();
    end
  end
  initial begin
    reset = 1'b1;
    local_bus = '{16'h2000, 1'b1, 1'b1, 1'b1};
    local_wdata = 8'h00;
    host_cmd = '0;
    host_upper_page = 1'b0;
    prio_in_n = 1'b1;
    slow = 1'b0;
    repeat (2) @(posedge mclk);
    #1 reset = 1'b0;
    repeat (3) @(posedge mclk);
    #1;
    for (int i = 0; i < 8; i++) begin
      local_bus.addr = 16'(i) << 10;
      #1 chk(region_select_n, 8'(~(8'h01 << i)));
    end
    local_bus.int_ack_n = 1'b0;
    #1 chk(region_select_n, 8'hff);
    local_bus = '{16'h2000, 1'b1, 1'b1, 1'b1};
    #1 chk(region_select_n, 8'hff);
    bus(16'h0817, 1'b0, 8'ha5, q);
    bus(16'h0917, 1'b0, 8'h5a, q);
    bus(16'h0817, 1'b1, 8'h00, q);
    chk(q, 8'ha5);
    bus(16'h0917, 1'b1, 8'h00, q);
    chk(q, 8'h5a);
    bus(16'h1800, 1'b1, 8'h00, q);
    chk(q, 8'h00);
    host_out(8'h3d, 8'h99);
    chk(cmd_pending_n, 1'b1);
    host_out(8'h3c, 8'hc3);
    chk(cmd_pending_n, 1'b0);
    bus(16'h1400, 1'b0, 8'h11, q);
    bus(16'h1800, 1'b1, 8'h00, q);
    chk(q, 8'h01);
    repeat (60) @(posedge mclk);
    chk(host_hold_req_n, 1'b0);
    chk(host_hold_oe_n, 1'b0);
    bus(16'h1400, 1'b1, 8'h00, q);
    chk(q, 8'hc3);
    repeat (60) @(posedge mclk);
    chk(host_hold_req_n, 1'b1);
    for (int s = 0; s < 2; s++) begin
      slow = 1'(s);
      host_upper_page = 1'(s);
      bus(16'h8123, 1'b1, 8'h00, q);
      chk(q, 8'hdc);
      bus(16'hc042, 1'b0, 8'h77, q);
      chk(wr_addr, {1'(s), 15'h4042});
      chk(wr_data, 8'h77);
    end
    // higher priority channel claims the bus before the host acknowledges
    fork
      host_out(8'h3c, 8'h5e);
      begin
        @(negedge host_hold_req_n);
        #1 prio_in_n = 1'b0;
      end
    join
    repeat (4) @(posedge mclk);
    #1 chk(host_hold_req_n, 1'b1);
    chk(prio_out_n, 1'b0);
    prio_in_n = 1'b1;
    bus(16'h1400, 1'b1, 8'h00, q);
    chk(q, 8'h5e);
    give_verdict();
  end
endmodule
bind dhb_bridge dhb_bridge_monitor u_mon (.mclk, .reset, .local_bus, .local_ready_in, .region_select_n,
  .cmd_pending_n, .cmd_latch_strobe, .dma_active, .prio_out_n, .host_bus_oe_n, .data_buf_en, .data_buf_to_local);
`default_nettype wire
